// >>> hdl/sli_pkg.sv
// Purpose: Shared constants and types for the seven-level interrupt prioritizer.
// Assumes: One 250 MHz clock, synchronous active-high reset.
// Notes: Word indexes are byte address bits 9:2 of the Avalon-MM slaves.
package sli_pkg;
	// ==================================================
	// Widths
	localparam int SRC_N = 64;
	localparam int SRC_W = 6;
	localparam int LVL_W = 3;
	localparam int RANK_W = 4;
	localparam int VEC_W = 8;
	localparam int CTRL_W = 8;
	localparam int PROG_N = 56;
	localparam int PROG_FIRST = 8;
	localparam int LVL_TOP = 7;
	localparam int VECTOR_FETCH_CYCLE_AW = 5;
	localparam int VECTOR_FETCH_CYCLE_LVL_LO = 2;
	localparam int VECTOR_FETCH_CYCLE_LVL_HI = 4;
	localparam int AV_AW = 10;
	localparam int AV_DW = 32;
	localparam int WORD_LO = 2;
	localparam int WORD_HI = 9;
	// ==================================================
	// Control byte layout and ranking
	localparam int LVL_LO = 3;
	localparam int LVL_HI = 5;
	localparam int PRIO_LO = 0;
	localparam int PRIO_HI = 2;
	localparam logic [2:0] PRIO_SPLIT = 3'h4;
	localparam logic [3:0] RANK_MID = 4'h4;
	localparam logic [2:0] LVL_NMI = 3'h7;
	localparam logic [2:0] LVL_NONE = 3'h0;
	localparam logic [7:0] VEC_BASE = 8'h40;
	localparam logic [7:0] VEC_SPUR = 8'h18;
	// ==================================================
	// Controller-end registers (word indexes)
	localparam logic [7:0] DW_PEND_HI = 8'h00;
	localparam logic [7:0] DW_PEND_LO = 8'h01;
	localparam logic [7:0] DW_MASK_HI = 8'h02;
	localparam logic [7:0] DW_MASK_LO = 8'h03;
	localparam logic [1:0] DW_CTRL_TAG = 2'h1;
	localparam int MASK_ALL_BIT = 0;
	localparam logic [63:0] MASK_RST = 64'hFFFF_FFFF_FFFF_FFFF;
	localparam logic [7:0] CTRL_RST = 8'h00;
	// ==================================================
	// Core-end registers (word indexes)
	localparam logic [7:0] CW_CTRL = 8'h00;
	localparam logic [7:0] CW_STAT = 8'h01;
	localparam logic [7:0] CW_EVT = 8'h02;
	localparam logic [7:0] CW_EMASK = 8'h03;
	localparam int EVT_W = 3;
	localparam int EV_TAKEN = 0;
	localparam int EV_SPUR = 1;
	localparam int EV_NMI = 2;
	localparam int STAT_LVL_LO = 8;
	localparam int STAT_HOLD = 16;
	localparam logic [2:0] CORE_MASK_RST = 3'h7;
	typedef enum logic [2:0] {
		SLI_IDLE = 3'b001,
		SLI_FETCH = 3'b010,
		SLI_HOLD = 3'b100
	} sli_core_state_t;
endpackage

// >>> hdl/sli_link_if.sv
// Purpose: Level and acknowledge link between prioritizer and core.
// Assumes: Both ends run on the same clock.
// Notes: vector_fetch_cycle_req marks the acknowledge byte fetch; it is held until vector_fetch_cycle_ack.
`timescale 1ns/100ps
interface sli_link_if;
	logic [2:0] level;
	logic vector_fetch_cycle_req;
	logic [4:0] vector_fetch_cycle_addr;
	logic vector_fetch_cycle_ack;
	logic [7:0] vector;
	modport ctrl(output level, input vector_fetch_cycle_req, input vector_fetch_cycle_addr, output vector_fetch_cycle_ack, output vector);
	modport core(input level, output vector_fetch_cycle_req, output vector_fetch_cycle_addr, input vector_fetch_cycle_ack, input vector);
endinterface

// >>> hdl/sli_level_pick.sv
// Purpose: Finds the highest-ranked active source at one level.
// Assumes: Rank 8 is the top slot of a level, rank 0 the bottom.
// Notes: Equal ranks go to the lowest source number.
`timescale 1ns/100ps
module sli_level_pick
	import sli_pkg::*;
(
	// Sources
	input wire logic [63:0] act_i,
	input wire logic [63:0][2:0] lvl_i,
	input wire logic [63:0][3:0] rank_i,
	// Query
	input wire logic [2:0] sel_i,
	output logic hit_o,
	output logic [5:0] src_o
);
	logic [3:0] best;
	always_comb begin
		hit_o = 1'b0;
		src_o = '0;
		best = '0;
		for (int i = 1; i < SRC_N; i++) begin
			if (act_i[i] && sel_i != LVL_NONE && lvl_i[i] == sel_i && (!hit_o || rank_i[i] > best)) begin
				hit_o = 1'b1;
				src_o = SRC_W'(i);
				best = rank_i[i];
			end
		end
	end
endmodule

// >>> hdl/sli_ctrl_end.sv
// Purpose: Interrupt prioritizer: 63 sources onto a 3-bit level, vector answer.
// Assumes: Requests come from logic on this clock; Avalon-MM slave with waitrequest.
// Notes: Control bytes for sources 1-7 read as zero and ignore writes.
// Contract
// - Three-bit level, seven highest, zero idle.
// - Core takes levels above its mask.
// - Level seven edge, unmaskable; others level-sensitive.
// - Peripheral holds request until software clears.
// - Acknowledge byte fetch answered with vector.
// - User vectors lie in 64 to 255.
// - Acknowledge never reaches the peripheral.
// - 63 sources, seven levels, nine slots.
// - Sources 1-7 fixed at level midpoint.
// - Sources 8-63 take programmed level, priority.
// - Priorities 7-4 above midpoint, 3-0 below.
// - Core raises its mask to taken level.
// - First handler instruction before next sample.
// - Acknowledged level from address bits 4:2.
// - Vector is 64 plus source number.
// - Empty level answers vector 24.
// - Per-level request vector encoded to level.
//
// The implementer's own choices: the placing of the registers and the Avalon-MM interface to the registers.
`timescale 1ns/100ps
module sli_ctrl_end
	import sli_pkg::*;
(
	// Clock and reset
	input wire logic clock_i,
	input wire logic rst_i,
	// Peripheral requests, bit n is source n
	input wire logic [63:1] src_req_i,
	// Core link
	sli_link_if.ctrl link,
	// Avalon-MM slave
	input wire logic [sli_pkg::AV_AW-1:0] avs_address_i,
	input wire logic avs_read_i,
	input wire logic avs_write_i,
	input wire logic [sli_pkg::AV_DW-1:0] avs_writedata_i,
	output logic [sli_pkg::AV_DW-1:0] avs_readdata_o,
	output logic avs_waitrequest_o
);
	import sli_pkg::*;

	// ==================================================
	// State
	typedef struct packed {
		logic [63:0] mask;
		logic [PROG_N-1:0][CTRL_W-1:0] ctrl;
		logic [LVL_W-1:0] level;
		logic ack;
		logic [VEC_W-1:0] vec;
		logic wreq;
		logic [AV_DW-1:0] rdata;
	} sli_dev_st_t;

	sli_dev_st_t st_reg;
	sli_dev_st_t st_next;

	logic [63:0] act;
	logic [63:0][2:0] src_lvl;
	logic [63:0][3:0] src_rank;
	logic [7:0] lvl_vec;
	logic pick_hit;
	logic [5:0] pick_src;
	logic [7:0] word;
	logic [5:0] cidx;

	// ==================================================
	// Source mapping
	// A masked source is dropped before ranking, so a masked request never reaches the level or the vector.
	assign act = st_reg.mask[MASK_ALL_BIT] ? '0 : ({src_req_i, 1'b0} & ~st_reg.mask);
	assign src_lvl[0] = LVL_NONE;
	assign src_rank[0] = '0;

	genvar gi;
	generate
		for (gi = 1; gi < SRC_N; gi++) begin : g_src
			if (gi < PROG_FIRST) begin : g_fixed
				assign src_lvl[gi] = LVL_W'(gi);
				assign src_rank[gi] = RANK_MID;
			end else begin : g_prog
				logic [2:0] prio;
				assign prio = st_reg.ctrl[gi-PROG_FIRST][PRIO_HI:PRIO_LO];
				assign src_lvl[gi] = st_reg.ctrl[gi-PROG_FIRST][LVL_HI:LVL_LO];
				// Upper priorities skip the midpoint slot, giving nine slots per level.
				assign src_rank[gi] = (prio >= PRIO_SPLIT) ? {1'b0, prio} + 4'h1 : {1'b0, prio};
			end
		end
	endgenerate

	sli_level_pick u_pick (
		.act_i(act),
		.lvl_i(src_lvl),
		.rank_i(src_rank),
		.sel_i(link.vector_fetch_cycle_addr[VECTOR_FETCH_CYCLE_LVL_HI:VECTOR_FETCH_CYCLE_LVL_LO]),
		.hit_o(pick_hit),
		.src_o(pick_src)
	);

	assign word = avs_address_i[WORD_HI:WORD_LO];
	assign cidx = word[5:0];

	// ==================================================
	// Next state
	always_comb begin
		st_next = st_reg;
		// Per-level request vector, then the highest set level.
		lvl_vec = '0;
		for (int i = 1; i < SRC_N; i++) begin
			if (act[i]) begin
				lvl_vec[src_lvl[i]] = 1'b1;
			end
		end
		st_next.level = LVL_NONE;
		for (int l = 1; l <= LVL_TOP; l++) begin
			if (lvl_vec[l]) begin
				st_next.level = LVL_W'(l);
			end
		end

		// The answer comes from here alone; the peripheral sees nothing of the fetch.
		st_next.ack = 1'b0;
		if (link.vector_fetch_cycle_req && !st_reg.ack) begin
			st_next.ack = 1'b1;
			st_next.vec = pick_hit ? VEC_BASE + {2'b00, pick_src} : VEC_SPUR;
		end

		// Bus slave: waitrequest drops one cycle after a request is seen.
		st_next.wreq = 1'b1;
		if ((avs_read_i || avs_write_i) && st_reg.wreq) begin
			st_next.wreq = 1'b0;
			st_next.rdata = '0;
			if (word == DW_PEND_HI) begin
				st_next.rdata = act[63:32];
			end else if (word == DW_PEND_LO) begin
				st_next.rdata = act[31:0];
			end else if (word == DW_MASK_HI) begin
				st_next.rdata = st_reg.mask[63:32];
			end else if (word == DW_MASK_LO) begin
				st_next.rdata = st_reg.mask[31:0];
			end else if (word[7:6] == DW_CTRL_TAG && cidx >= SRC_W'(PROG_FIRST)) begin
				st_next.rdata = {24'h00_0000, st_reg.ctrl[cidx - SRC_W'(PROG_FIRST)]};
			end
		end
		if (avs_write_i && !st_reg.wreq) begin
			if (word == DW_MASK_HI) begin
				st_next.mask[63:32] = avs_writedata_i;
			end else if (word == DW_MASK_LO) begin
				st_next.mask[31:0] = avs_writedata_i;
			end else if (word[7:6] == DW_CTRL_TAG && cidx >= SRC_W'(PROG_FIRST)) begin
				st_next.ctrl[cidx - SRC_W'(PROG_FIRST)] = avs_writedata_i[CTRL_W-1:0];
			end
		end
	end

	// ==================================================
	// Registers
	always_ff @(posedge clock_i) begin
		if (rst_i) begin
			st_reg.mask <= MASK_RST;
			st_reg.ctrl <= {PROG_N{CTRL_RST}};
			st_reg.level <= LVL_NONE;
			st_reg.ack <= 1'b0;
			st_reg.vec <= VEC_SPUR;
			st_reg.wreq <= 1'b1;
			st_reg.rdata <= '0;
		end else begin
			st_reg <= st_next;
		end
	end

	assign link.level = st_reg.level;
	assign link.vector_fetch_cycle_ack = st_reg.ack;
	assign link.vector = st_reg.vec;
	assign avs_readdata_o = st_reg.rdata;
	assign avs_waitrequest_o = st_reg.wreq;
endmodule

// >>> hdl/sli_core_end.sv
// Purpose: Core side: samples the level, runs acknowledge fetches, reports vectors.
// Assumes: Software plays the handler; reading the status word is its first instruction.
// Notes: A level-7 rise seen while busy is remembered and taken once sampling resumes.
`timescale 1ns/100ps
module sli_core_end
	import sli_pkg::*;
(
	// Clock and reset
	input wire logic clock_i,
	input wire logic rst_i,
	// Prioritizer link
	sli_link_if.core link,
	// Avalon-MM slave
	input wire logic [sli_pkg::AV_AW-1:0] avs_address_i,
	input wire logic avs_read_i,
	input wire logic avs_write_i,
	input wire logic [sli_pkg::AV_DW-1:0] avs_writedata_i,
	output logic [sli_pkg::AV_DW-1:0] avs_readdata_o,
	output logic avs_waitrequest_o,
	// Interrupt
	output logic irq_o
);
	import sli_pkg::*;

	// ==================================================
	// State
	typedef struct packed {
		sli_core_state_t fsm;
		logic [LVL_W-1:0] mask;
		logic prev7;
		logic nmi_pend;
		logic req;
		logic [VECTOR_FETCH_CYCLE_AW-1:0] addr;
		logic [VEC_W-1:0] vec;
		logic [LVL_W-1:0] taken;
		logic [EVT_W-1:0] evt;
		logic [EVT_W-1:0] emask;
		logic irq;
		logic wreq;
		logic [AV_DW-1:0] rdata;
	} sli_core_st_t;

	sli_core_st_t st_reg;
	sli_core_st_t st_next;
	logic [7:0] word;
	logic rd_take;

	assign word = avs_address_i[WORD_HI:WORD_LO];
	assign rd_take = avs_read_i && st_reg.wreq;

	// ==================================================
	// Next state
	always_comb begin
		st_next = st_reg;
		// Level 7 counts only on its rising edge and ignores the mask.
		st_next.prev7 = (link.level == LVL_NMI);
		if (link.level == LVL_NMI && !st_reg.prev7) begin
			st_next.nmi_pend = 1'b1;
		end
		if (rd_take && word == CW_EVT) begin
			st_next.evt = '0;
		end

		unique case (st_reg.fsm)
			SLI_IDLE: begin
				if (st_next.nmi_pend) begin
					st_next.nmi_pend = 1'b0;
					st_next.req = 1'b1;
					st_next.addr = {LVL_NMI, 2'b00};
					st_next.fsm = SLI_FETCH;
				end else if (link.level != LVL_NMI && link.level > st_reg.mask) begin
					st_next.req = 1'b1;
					st_next.addr = {link.level, 2'b00};
					st_next.fsm = SLI_FETCH;
				end
			end
			SLI_FETCH: begin
				if (link.vector_fetch_cycle_ack) begin
					st_next.req = 1'b0;
					st_next.vec = link.vector;
					st_next.taken = st_reg.addr[VECTOR_FETCH_CYCLE_LVL_HI:VECTOR_FETCH_CYCLE_LVL_LO];
					st_next.mask = st_reg.addr[VECTOR_FETCH_CYCLE_LVL_HI:VECTOR_FETCH_CYCLE_LVL_LO];
					st_next.evt[EV_TAKEN] = 1'b1;
					// Build on the cleared copy so a read in the same cycle still clears the bits not set now.
					st_next.evt[EV_SPUR] = st_next.evt[EV_SPUR] || (link.vector == VEC_SPUR);
					st_next.evt[EV_NMI] = st_next.evt[EV_NMI] || (st_reg.addr[VECTOR_FETCH_CYCLE_LVL_HI:VECTOR_FETCH_CYCLE_LVL_LO] == LVL_NMI);
					st_next.fsm = SLI_HOLD;
				end
			end
			SLI_HOLD: begin
				// No sampling until the handler has run its first access.
				if (rd_take && word == CW_STAT) begin
					st_next.fsm = SLI_IDLE;
				end
			end
		endcase

		st_next.wreq = 1'b1;
		if ((avs_read_i || avs_write_i) && st_reg.wreq) begin
			st_next.wreq = 1'b0;
			st_next.rdata = '0;
			if (word == CW_CTRL) begin
				st_next.rdata = {29'h0, st_reg.mask};
			end else if (word == CW_STAT) begin
				st_next.rdata = {15'h0, st_reg.fsm == SLI_HOLD, 5'h0, st_reg.taken, st_reg.vec};
			end else if (word == CW_EVT) begin
				st_next.rdata = {29'h0, st_reg.evt};
			end else if (word == CW_EMASK) begin
				st_next.rdata = {29'h0, st_reg.emask};
			end
		end
		if (avs_write_i && !st_reg.wreq) begin
			if (word == CW_CTRL) begin
				st_next.mask = avs_writedata_i[LVL_W-1:0];
			end else if (word == CW_EMASK) begin
				st_next.emask = avs_writedata_i[EVT_W-1:0];
			end
		end
		st_next.irq = |(st_next.evt & st_next.emask);
	end

	// ==================================================
	// Registers
	always_ff @(posedge clock_i) begin
		if (rst_i) begin
			st_reg.fsm <= SLI_IDLE;
			st_reg.mask <= CORE_MASK_RST;
			st_reg.prev7 <= 1'b0;
			st_reg.nmi_pend <= 1'b0;
			st_reg.req <= 1'b0;
			st_reg.addr <= '0;
			st_reg.vec <= '0;
			st_reg.taken <= '0;
			st_reg.evt <= '0;
			st_reg.emask <= '0;
			st_reg.irq <= 1'b0;
			st_reg.wreq <= 1'b1;
			st_reg.rdata <= '0;
		end else begin
			st_reg <= st_next;
		end
	end

	assign link.vector_fetch_cycle_req = st_reg.req;
	assign link.vector_fetch_cycle_addr = st_reg.addr;
	assign avs_readdata_o = st_reg.rdata;
	assign avs_waitrequest_o = st_reg.wreq;
	assign irq_o = st_reg.irq;
endmodule

// >>> bench/sli_link_assertions.sv
// Purpose: Link checks between prioritizer end and core end.
// Assumes: One clock, synchronous active-high reset.
// Notes: Sees only the interface signals.
`timescale 1ns/100ps
module sli_link_assertions (
	// Clock and reset
	input wire logic clock_i,
	input wire logic rst_i,
	// Link
	input wire logic [2:0] level,
	input wire logic vector_fetch_cycle_req,
	input wire logic [4:0] vector_fetch_cycle_addr,
	input wire logic vector_fetch_cycle_ack,
	input wire logic [7:0] vector
);
	// ==================================================
	// Properties
	default clocking @(posedge clock_i); endclocking
	default disable iff (rst_i);
	property p_rst_idle;
		$fell(rst_i) |-> level == 3'h0 && !vector_fetch_cycle_ack && vector == 8'h18;
	endproperty
	a_rst_idle: assert property (p_rst_idle) else $error("link not idle after reset");
	property p_ack_next;
		vector_fetch_cycle_req && !vector_fetch_cycle_ack |=> vector_fetch_cycle_ack;
	endproperty
	a_ack_next: assert property (p_ack_next) else $error("fetch not answered next cycle");
	property p_ack_pulse;
		vector_fetch_cycle_ack |=> !vector_fetch_cycle_ack;
	endproperty
	a_ack_pulse: assert property (p_ack_pulse) else $error("answer longer than one cycle");
	property p_ack_cause;
		$rose(vector_fetch_cycle_ack) |-> $past(vector_fetch_cycle_req);
	endproperty
	a_ack_cause: assert property (p_ack_cause) else $error("answer without fetch");
	property p_req_hold;
		vector_fetch_cycle_req && !vector_fetch_cycle_ack |=> vector_fetch_cycle_req && $stable(vector_fetch_cycle_addr);
	endproperty
	a_req_hold: assert property (p_req_hold) else $error("fetch dropped early");
	property p_req_drop;
		vector_fetch_cycle_ack |=> !vector_fetch_cycle_req;
	endproperty
	a_req_drop: assert property (p_req_drop) else $error("fetch kept after answer");
	property p_vec_range;
		vector_fetch_cycle_ack |-> vector == 8'h18 || (vector > 8'h40 && vector < 8'h80);
	endproperty
	a_vec_range: assert property (p_vec_range) else $error("vector out of range");
	property p_vec_hold;
		!vector_fetch_cycle_ack |-> $stable(vector);
	endproperty
	a_vec_hold: assert property (p_vec_hold) else $error("vector moved between answers");
	property p_addr_form;
		vector_fetch_cycle_req |-> vector_fetch_cycle_addr[1:0] == 2'h0 && vector_fetch_cycle_addr[4:2] != 3'h0;
	endproperty
	a_addr_form: assert property (p_addr_form) else $error("bad fetch address");
	property p_fixed_vec;
		vector_fetch_cycle_ack && vector > 8'h40 && vector < 8'h48 |-> vector[2:0] == vector_fetch_cycle_addr[4:2];
	endproperty
	a_fixed_vec: assert property (p_fixed_vec) else $error("fixed source at wrong level");
endmodule

// >>> bench/test_seven_level_interrupt_prioritizer.sv
// Purpose: Self-checking bench for both ends of the prioritizer link.
// Assumes: Model mirrors masks, control bytes and requests as written.
// Notes: Requests drop between rounds so that level seven always rises.
`timescale 1ns/100ps
module test_seven_level_interrupt_prioritizer;
	import sli_pkg::*;
	// ==================================================
	// Signals and instances
	logic clock_i, rst_i, b_sel, b_rd, b_wr, d_wq, c_wq, irq, pulse;
	logic [63:1] src;
	logic [9:0] b_a;
	logic [31:0] b_wd, d_rq, c_rq, q, seed, r;
	logic [63:0] req_m, mask_m, p;
	int lvl_of[64], rank_of[64];
	int n_errors, compares, acks, a0, n, lastv_m, lastl_m, evt_m, emask_m;
	sli_link_if link();
	sli_ctrl_end sli_ctrl_end_inst (.clock_i(clock_i), .rst_i(rst_i), .src_req_i(src), .link(link.ctrl),
		.avs_address_i(b_a), .avs_read_i(b_rd & !b_sel), .avs_write_i(b_wr & !b_sel),
		.avs_writedata_i(b_wd), .avs_readdata_o(d_rq), .avs_waitrequest_o(d_wq));
	sli_core_end sli_core_end_inst (.clock_i(clock_i), .rst_i(rst_i), .link(link.core),
		.avs_address_i(b_a), .avs_read_i(b_rd & b_sel), .avs_write_i(b_wr & b_sel),
		.avs_writedata_i(b_wd), .avs_readdata_o(c_rq), .avs_waitrequest_o(c_wq), .irq_o(irq));
	sli_link_assertions sli_link_assertions_inst (.clock_i(clock_i), .rst_i(rst_i), .level(link.level),
		.vector_fetch_cycle_req(link.vector_fetch_cycle_req), .vector_fetch_cycle_addr(link.vector_fetch_cycle_addr), .vector_fetch_cycle_ack(link.vector_fetch_cycle_ack), .vector(link.vector));
	// ==================================================
	// Model and tasks
	function automatic logic [31:0] rnd();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed;
	endfunction
	function automatic bit act(int s);
		return req_m[s] && !mask_m[s] && !mask_m[0];
	endfunction
	function automatic int top_lvl();
		int b;
		b = 0;
		for (int s = 1; s < 64; s++) begin
			if (act(s) && lvl_of[s] > b) b = lvl_of[s];
		end
		return b;
	endfunction
	function automatic int pick(int l);
		int w, k;
		w = 0;
		k = -1;
		for (int s = 1; s < 64; s++) begin
			if (act(s) && lvl_of[s] == l && rank_of[s] > k) begin
				w = s;
				k = rank_of[s];
			end
		end
		return (w == 0) ? 24 : 64 + w;
	endfunction
	task automatic check(string nm, logic [31:0] e, logic [31:0] g);
		compares++;
		if (g !== e) begin
			n_errors++;
			$display("CHECK FAILED %s expected %h seen %h", nm, e, g);
		end
	endtask
	task automatic print_verdict();
		if (n_errors == 0 && compares > 0) begin
			$display("All checks passed");
		end else begin
			$display("Checks failed");
		end
		$finish;
	endtask
	// A wait that runs out counts as a mismatch rather than hanging the run.
	task automatic bus(logic sel, logic wr, logic [9:0] a, logic [31:0] d);
		int k;
		k = 0;
		b_sel <= sel;
		b_a <= a;
		b_wd <= d;
		b_wr <= wr;
		b_rd <= !wr;
		do begin
			@(posedge clock_i);
			k++;
		end while ((sel ? c_wq : d_wq) !== 1'b0 && k < 50);
		if (k >= 50) n_errors++;
		q = sel ? c_rq : d_rq;
		b_rd <= 1'b0;
		b_wr <= 1'b0;
		@(posedge clock_i);
	endtask
	task automatic rd(logic sel, logic [9:0] a, logic [31:0] e, string nm);
		bus(sel, 1'b0, a, 32'h0);
		check(nm, e, q);
	endtask
	task automatic do_reset();
		rst_i <= 1'b1;
		repeat (2) @(posedge clock_i);
		rst_i <= 1'b0;
		@(posedge clock_i);
		mask_m = '1;
		evt_m = 0;
	endtask
	always @(negedge clock_i) begin
		if (!rst_i && link.vector_fetch_cycle_ack === 1'b1) begin
			lastl_m = link.vector_fetch_cycle_addr[4:2];
			lastv_m = pick(lastl_m);
			check("vector", lastv_m, link.vector);
			evt_m |= 1 | (lastv_m == 24 ? 2 : 0) | (lastl_m == 7 ? 4 : 0);
			acks++;
		end
	end
	// ==================================================
	// Stimulus
	initial begin
		clock_i = 1'b0;
		forever #2 clock_i = !clock_i;
	end
	initial begin
		#60000;
		n_errors++;
		print_verdict();
	end
	initial begin
		{rst_i, b_sel, b_rd, b_wr} = 4'h8;
		{b_a, b_wd, src, req_m} = '0;
		{n_errors, compares, acks} = '0;
		seed = 32'hB201;
		for (int s = 0; s < 8; s++) begin
			lvl_of[s] = s;
			rank_of[s] = 4;
		end
		@(posedge clock_i);
		do_reset();
		rd(1'b0, 10'h008, 32'hFFFFFFFF, "mask hi");
		rd(1'b1, 10'h000, 32'h7, "core mask");
		rd(1'b0, 10'h010, 32'h0, "unmapped");
		src <= '1;
		repeat (2) @(posedge clock_i);
		check("masked level", 0, link.level);
		bus(1'b0, 1'b1, 10'h10C, 32'h3F);
		rd(1'b0, 10'h10C, 32'h0, "fixed control");
		for (int s = 8; s < 64; s++) begin
			r = rnd() & 32'h3F;
			lvl_of[s] = r[5:3];
			rank_of[s] = r[2:0] >= 4 ? r[2:0] + 1 : r[2:0];
			bus(1'b0, 1'b1, 10'(256 + 4 * s), r);
			rd(1'b0, 10'(256 + 4 * s), r, "control");
		end
		for (int i = 0; i < 40; i++) begin
			src <= '0;
			req_m = '0;
			mask_m = {rnd() & rnd(), rnd() & rnd()};
			mask_m[0] = (rnd() & 7) == 0;
			emask_m = rnd() & 7;
			bus(1'b0, 1'b1, 10'h008, mask_m[63:32]);
			bus(1'b0, 1'b1, 10'h00C, mask_m[31:0]);
			bus(1'b1, 1'b1, 10'h00C, emask_m);
			bus(1'b1, 1'b1, 10'h000, 32'h0);
			pulse = (rnd() & 3) == 0;
			r = rnd() & rnd() & rnd() & rnd();
			src <= 63'({r, rnd() & rnd() & rnd() & rnd()} >> 1);
			req_m = {r, seed & seed} & 64'hFFFFFFFF_FFFFFFFE;
			req_m = {src, 1'b0};
			@(posedge clock_i);
			req_m = {src, 1'b0};
			if (pulse) begin
				src <= '0;
				req_m = '0;
			end
			@(posedge clock_i);
			if (!pulse) check("level", top_lvl(), link.level);
			a0 = acks;
			for (n = 0; n < 30 && acks == a0; n++) @(posedge clock_i);
			if (!pulse && top_lvl() != 0) check("taken", 1, acks - a0);
			repeat (3) @(posedge clock_i);
			check("irq", (evt_m & emask_m) != 0, irq);
			p = req_m & ~mask_m & {63'h7FFFFFFF_FFFFFFFF, 1'b0};
			if (mask_m[0]) p = '0;
			rd(1'b0, 10'h004, p[31:0], "pending lo");
			rd(1'b0, 10'h000, p[63:32], "pending hi");
			if (acks != a0) begin
				rd(1'b1, 10'h004, {15'h0, 1'b1, 5'h0, 3'(lastl_m), 8'(lastv_m)}, "status");
				rd(1'b1, 10'h000, lastl_m, "raised mask");
			end
			rd(1'b1, 10'h008, evt_m, "events");
			evt_m = 0;
			repeat (3) @(posedge clock_i);
			check("irq clear", 0, irq);
		end
		do_reset();
		rd(1'b0, 10'h00C, 32'hFFFFFFFF, "mask lo");
		check("reset level", 0, link.level);
		print_verdict();
	end
endmodule
